/* File: hdl/i2crap_device.sv */
`timescale 1ns/1ps
`default_nettype none
module i2crap_device #(
  parameter int REG_COUNT = i2crap_pkg::REG_COUNT
) (
  input  wire logic                          clock,
  input  wire logic                          rst_b,
  i2crap_bus_if.device                       bus,
  input  wire logic                          loc_wr_en,
  input  wire logic [i2crap_pkg::BYTE_W-1:0] loc_wr_index,
  input  wire logic [i2crap_pkg::BYTE_W-1:0] loc_wr_data,
  output logic                               wr_pulse,
  output logic      [i2crap_pkg::BYTE_W-1:0] wr_index,
  output logic      [i2crap_pkg::BYTE_W-1:0] wr_data,
  output logic                               auto_inc,
  output logic                               busy
);
  import i2crap_pkg::*;

  localparam int IDX_W = $clog2(REG_COUNT);

  // -------------------------------------------------------------------
  // Synchronisers and edge history
  // -------------------------------------------------------------------
  logic scl_m_ff, scl_s_ff, scl_d_ff;
  logic sda_m_ff, sda_s_ff, sda_d_ff;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      scl_m_ff <= 1'b1;
      scl_s_ff <= 1'b1;
      scl_d_ff <= 1'b1;
      sda_m_ff <= 1'b1;
      sda_s_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_m_ff <= bus.scl;
      scl_s_ff <= scl_m_ff;
      scl_d_ff <= scl_s_ff;
      sda_m_ff <= bus.sda;
      sda_s_ff <= sda_m_ff;
      sda_d_ff <= sda_s_ff;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;

  assign scl_rise  = scl_s_ff && !scl_d_ff;
  assign scl_fall  = !scl_s_ff && scl_d_ff;
  assign bus_start = scl_s_ff && scl_d_ff && sda_d_ff && !sda_s_ff;
  assign bus_stop  = scl_s_ff && scl_d_ff && !sda_d_ff && sda_s_ff;

  // Engine state is declared here because the array write mux reads it
  i2crap_dev_st_t    st_ff, nxt_st;
  logic [3:0]        bit_ff, nxt_bit;
  logic [BYTE_W-1:0] shift_ff, nxt_shift;
  logic [1:0]        phase_ff, nxt_phase;
  logic              rd_mode_ff, nxt_rd_mode;
  logic [BYTE_W-1:0] ptr_ff, nxt_ptr;
  logic              sda_oe_ff, nxt_sda_oe;
  logic              host_ack_ff, nxt_host_ack;
  logic              wr_pulse_n;
  logic              wr_pulse_ff;
  logic [BYTE_W-1:0] wr_index_ff, wr_data_ff;

  // -------------------------------------------------------------------
  // Register array
  // -------------------------------------------------------------------
  logic [BYTE_W-1:0] mem_ff [REG_COUNT];
  logic              mem_we;
  logic [BYTE_W-1:0] mem_wa;
  logic [BYTE_W-1:0] mem_wd;

  function automatic logic [BYTE_W-1:0] reg_value(
    input logic [BYTE_W-1:0] idx
  );
    logic [BYTE_W-1:0] val;
    val = 8'h00;
    if (32'(idx) < REG_COUNT) begin
      val = mem_ff[idx[IDX_W-1:0]];
    end
    return val;
  endfunction : reg_value

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        mem_ff[i] <= REG_RESET;
      end
    end else if (mem_we && (32'(mem_wa) < REG_COUNT)) begin
      mem_ff[mem_wa[IDX_W-1:0]] <= mem_wd;
    end
  end

  // Bus writes take priority over local updates in the same cycle
  always_comb begin
    mem_we = loc_wr_en;
    mem_wa = loc_wr_index;
    mem_wd = loc_wr_data;
    if (wr_pulse_n) begin
      mem_we = 1'b1;
      mem_wa = ptr_ff;
      mem_wd = shift_ff;
    end
  end

  assign auto_inc = mem_ff[CFG_INDEX[IDX_W-1:0]][CFG_AUTO_INC_BIT];

  // -------------------------------------------------------------------
  // Protocol engine
  // -------------------------------------------------------------------
  always_comb begin
    logic              ack;
    logic [BYTE_W-1:0] next_ptr;
    ack          = 1'b0;
    next_ptr     = ptr_ff;
    nxt_st       = st_ff;
    nxt_bit      = bit_ff;
    nxt_shift    = shift_ff;
    nxt_phase    = phase_ff;
    nxt_rd_mode  = rd_mode_ff;
    nxt_ptr      = ptr_ff;
    nxt_sda_oe   = sda_oe_ff;
    nxt_host_ack = host_ack_ff;
    wr_pulse_n   = 1'b0;
    if (bus_stop) begin
      nxt_st     = DS_IDLE;
      nxt_sda_oe = 1'b0;
    end else if (bus_start) begin
      // Pointer is left alone so a read after restart uses it
      nxt_st      = DS_RX;
      nxt_bit     = 4'h0;
      nxt_phase   = 2'h0;
      nxt_rd_mode = 1'b0;
      nxt_sda_oe  = 1'b0;
    end else begin
      case (st_ff)
        DS_RX: begin
          if (scl_rise && (bit_ff < ACK_SLOT)) begin
            nxt_shift = {shift_ff[BYTE_W-2:0], sda_s_ff};
            nxt_bit   = bit_ff + 4'h1;
          end
          if (scl_fall && (bit_ff == ACK_SLOT)) begin
            case (phase_ff)
              2'h0: begin
                if (shift_ff == ADDR_WR) begin
                  ack = 1'b1;
                end else if (shift_ff == ADDR_RD) begin
                  ack         = 1'b1;
                  nxt_rd_mode = 1'b1;
                end
              end
              2'h1: begin
                ack     = 1'b1;
                nxt_ptr = shift_ff;
              end
              2'h2: begin
                ack        = 1'b1;
                wr_pulse_n = 1'b1;
              end
              default: ack = 1'b0;
            endcase
            // Extra write bytes are refused: no burst writes
            if (ack) begin
              nxt_st     = DS_ACK;
              nxt_sda_oe = 1'b1;
              if (phase_ff != 2'h3) begin
                nxt_phase = phase_ff + 2'h1;
              end
            end else begin
              nxt_st = DS_WAIT;
            end
          end
        end
        DS_ACK: begin
          if (scl_fall) begin
            nxt_bit = 4'h0;
            if (rd_mode_ff) begin
              nxt_st     = DS_TX;
              nxt_shift  = reg_value(ptr_ff);
              nxt_sda_oe = !nxt_shift[BYTE_W-1];
            end else begin
              nxt_st     = DS_RX;
              nxt_sda_oe = 1'b0;
            end
          end
        end
        DS_TX: begin
          if (scl_fall) begin
            if (bit_ff == LAST_BIT) begin
              nxt_st     = DS_RACK;
              nxt_sda_oe = 1'b0;
            end else begin
              nxt_shift  = {shift_ff[BYTE_W-2:0], 1'b0};
              nxt_sda_oe = !shift_ff[BYTE_W-2];
              nxt_bit    = bit_ff + 4'h1;
            end
          end
        end
        DS_RACK: begin
          if (scl_rise) begin
            nxt_host_ack = !sda_s_ff;
          end
          if (scl_fall) begin
            if (host_ack_ff) begin
              if (auto_inc) begin
                next_ptr = ptr_ff + 8'h01;
              end
              nxt_ptr    = next_ptr;
              nxt_st     = DS_TX;
              nxt_bit    = 4'h0;
              nxt_shift  = reg_value(next_ptr);
              nxt_sda_oe = !nxt_shift[BYTE_W-1];
            end else begin
              nxt_st = DS_WAIT;
            end
          end
        end
        DS_IDLE, DS_WAIT: nxt_st = st_ff;
        default: nxt_st = DS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_ff       <= DS_IDLE;
      bit_ff      <= 4'h0;
      shift_ff    <= 8'h00;
      phase_ff    <= 2'h0;
      rd_mode_ff  <= 1'b0;
      ptr_ff      <= 8'h00;
      sda_oe_ff   <= 1'b0;
      host_ack_ff <= 1'b0;
      wr_pulse_ff <= 1'b0;
      wr_index_ff <= 8'h00;
      wr_data_ff  <= 8'h00;
    end else begin
      st_ff       <= nxt_st;
      bit_ff      <= nxt_bit;
      shift_ff    <= nxt_shift;
      phase_ff    <= nxt_phase;
      rd_mode_ff  <= nxt_rd_mode;
      ptr_ff      <= nxt_ptr;
      sda_oe_ff   <= nxt_sda_oe;
      host_ack_ff <= nxt_host_ack;
      wr_pulse_ff <= wr_pulse_n;
      if (wr_pulse_n) begin
        wr_index_ff <= ptr_ff;
        wr_data_ff  <= shift_ff;
      end
    end
  end

  // Open drain: only ever pulls low
  assign bus.dev_sda_out = 1'b0;
  assign bus.dev_sda_oe  = sda_oe_ff;
  assign wr_pulse        = wr_pulse_ff;
  assign wr_index        = wr_index_ff;
  assign wr_data         = wr_data_ff;
  assign busy            = (st_ff != DS_IDLE);
endmodule : i2crap_device
`default_nettype wire

/* File: hdl/i2crap_host.sv */
`timescale 1ns/1ps
`default_nettype none
module i2crap_host #(
  parameter int QTR_CYC = i2crap_pkg::SCL_QTR_CYC
) (
  input  wire logic                          clock,
  input  wire logic                          rst_b,
  i2crap_bus_if.host                         bus,
  input  wire logic                          cmd_valid,
  input  wire logic                          cmd_read,
  input  wire logic [i2crap_pkg::BYTE_W-1:0] cmd_index,
  input  wire logic [i2crap_pkg::BYTE_W-1:0] cmd_wdata,
  output logic                               cmd_ready,
  output logic                               done,
  output logic      [i2crap_pkg::BYTE_W-1:0] rd_data,
  output logic                               nack_err
);
  import i2crap_pkg::*;

  // -------------------------------------------------------------------
  // Data line synchroniser and quarter-bit divider
  // -------------------------------------------------------------------
  logic sda_m_ff, sda_s_ff;
  logic [7:0] div_ff, nxt_div;
  logic       tick;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sda_m_ff <= 1'b1;
      sda_s_ff <= 1'b1;
    end else begin
      sda_m_ff <= bus.sda;
      sda_s_ff <= sda_m_ff;
    end
  end

  // -------------------------------------------------------------------
  // Transaction sequencer
  // -------------------------------------------------------------------
  i2crap_host_st_t   st_ff, nxt_st;
  logic [1:0]        q_ff, nxt_q;
  logic [2:0]        step_ff, nxt_step;
  logic [3:0]        bit_ff, nxt_bit;
  logic [BYTE_W-1:0] tx_ff, nxt_tx, rx_ff, nxt_rx;
  logic [BYTE_W-1:0] idx_ff, nxt_idx, wd_ff, nxt_wd;
  logic [BYTE_W-1:0] rd_ff, nxt_rd;
  logic              read_ff, nxt_read;
  logic              scl_oe_ff, nxt_scl_oe, sda_oe_ff, nxt_sda_oe;
  logic              err_ff, nxt_err, done_ff, nxt_done;

  assign tick = (st_ff != HS_IDLE) && (32'(div_ff) == QTR_CYC - 1);

  // Write: start, addr, index, data, stop. Read puts restart, 0x69 and a read byte in place of data.
  function automatic i2crap_host_st_t step_kind(
    input logic rd, input logic [2:0] s
  );
    i2crap_host_st_t k;
    k = HS_BYTE;
    if (s == 3'h0 || (rd && s == 3'h3)) begin
      k = HS_START;
    end else if ((!rd && s == 3'h4) || (rd && s == 3'h6)) begin
      k = HS_STOP;
    end
    return k;
  endfunction : step_kind

  function automatic logic [BYTE_W-1:0] step_byte(
    input logic rd, input logic [2:0] s,
    input logic [BYTE_W-1:0] ix, input logic [BYTE_W-1:0] wd
  );
    logic [BYTE_W-1:0] b;
    case (s)
      3'h1:    b = ADDR_WR;
      3'h2:    b = ix;
      3'h3:    b = wd;
      3'h4:    b = ADDR_RD;
      default: b = READ_IDLE_BYTE;
    endcase
    if (!rd && s == 3'h3) b = wd;
    return b;
  endfunction : step_byte

  always_comb begin
    logic rd_byte;
    rd_byte    = read_ff && (step_ff == 3'h5);
    nxt_div    = (st_ff == HS_IDLE || tick) ? 8'h00 : div_ff + 8'h01;
    nxt_st     = st_ff;
    nxt_q      = q_ff;
    nxt_step   = step_ff;
    nxt_bit    = bit_ff;
    nxt_tx     = tx_ff;
    nxt_rx     = rx_ff;
    nxt_idx    = idx_ff;
    nxt_wd     = wd_ff;
    nxt_rd     = rd_ff;
    nxt_read   = read_ff;
    nxt_scl_oe = scl_oe_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_err    = err_ff;
    nxt_done   = 1'b0;
    if (st_ff == HS_IDLE) begin
      if (cmd_valid) begin
        nxt_st   = HS_START;
        nxt_q    = 2'h0;
        nxt_step = 3'h0;
        nxt_read = cmd_read;
        nxt_idx  = cmd_index;
        nxt_wd   = cmd_wdata;
        nxt_err  = 1'b0;
      end
    end else if (tick) begin
      nxt_q = q_ff + 2'h1;
      case (st_ff)
        HS_START: begin
          case (q_ff)
            2'h0:    nxt_sda_oe = 1'b0;
            2'h1:    nxt_scl_oe = 1'b0;
            2'h2:    nxt_sda_oe = 1'b1;
            default: nxt_scl_oe = 1'b1;
          endcase
        end
        HS_BYTE: begin
          case (q_ff)
            // Ack slot of a read byte stays released: a nack
            2'h0:    nxt_sda_oe = (bit_ff < ACK_SLOT) && !tx_ff[7];
            2'h1:    nxt_scl_oe = 1'b0;
            2'h2: begin
              if (bit_ff < ACK_SLOT) begin
                nxt_rx = {rx_ff[BYTE_W-2:0], sda_s_ff};
              end else if (!rd_byte && sda_s_ff) begin
                nxt_err = 1'b1;
              end
            end
            default: begin
              nxt_scl_oe = 1'b1;
              nxt_bit    = bit_ff + 4'h1;
              nxt_tx     = {tx_ff[BYTE_W-2:0], 1'b1};
            end
          endcase
        end
        HS_STOP: begin
          case (q_ff)
            2'h0:    nxt_sda_oe = 1'b1;
            2'h1:    nxt_scl_oe = 1'b0;
            2'h2:    nxt_sda_oe = 1'b0;
            default: nxt_sda_oe = 1'b0;
          endcase
        end
        default: nxt_st = HS_IDLE;
      endcase
      if (q_ff == 2'h3 && (st_ff != HS_BYTE || bit_ff == ACK_SLOT)) begin
        nxt_bit  = 4'h0;
        nxt_step = step_ff + 3'h1;
        if (st_ff == HS_STOP) begin
          nxt_st   = HS_IDLE;
          nxt_done = 1'b1;
          if (read_ff) nxt_rd = rx_ff;
        end else if (err_ff) begin
          nxt_step = read_ff ? 3'h6 : 3'h4;
          nxt_st   = HS_STOP;
        end else begin
          nxt_st = step_kind(read_ff, nxt_step);
          nxt_tx = step_byte(read_ff, nxt_step, idx_ff, wd_ff);
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      div_ff    <= 8'h00;
      st_ff     <= HS_IDLE;
      q_ff      <= 2'h0;
      step_ff   <= 3'h0;
      bit_ff    <= 4'h0;
      tx_ff     <= 8'h00;
      rx_ff     <= 8'h00;
      idx_ff    <= 8'h00;
      wd_ff     <= 8'h00;
      rd_ff     <= 8'h00;
      read_ff   <= 1'b0;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      err_ff    <= 1'b0;
      done_ff   <= 1'b0;
    end else begin
      div_ff    <= nxt_div;
      st_ff     <= nxt_st;
      q_ff      <= nxt_q;
      step_ff   <= nxt_step;
      bit_ff    <= nxt_bit;
      tx_ff     <= nxt_tx;
      rx_ff     <= nxt_rx;
      idx_ff    <= nxt_idx;
      wd_ff     <= nxt_wd;
      rd_ff     <= nxt_rd;
      read_ff   <= nxt_read;
      scl_oe_ff <= nxt_scl_oe;
      sda_oe_ff <= nxt_sda_oe;
      err_ff    <= nxt_err;
      done_ff   <= nxt_done;
    end
  end

  assign bus.host_scl_out = 1'b0;
  assign bus.host_scl_oe  = scl_oe_ff;
  assign bus.host_sda_out = 1'b0;
  assign bus.host_sda_oe  = sda_oe_ff;
  assign cmd_ready        = (st_ff == HS_IDLE);
  assign done             = done_ff;
  assign rd_data          = rd_ff;
  assign nack_err         = err_ff;
endmodule : i2crap_host
`default_nettype wire

/* File: shared/i2crap_bus_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface i2crap_bus_if;
  logic host_scl_out;
  logic host_scl_oe;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // -------------------------------------------------------------------
  // Wired-AND with pull-ups: any enabled low driver wins
  // -------------------------------------------------------------------
  assign scl = !(host_scl_oe && !host_scl_out);
  assign sda = !((host_sda_oe && !host_sda_out) ||
                 (dev_sda_oe && !dev_sda_out));

  modport host (
    output host_scl_out,
    output host_scl_oe,
    output host_sda_out,
    output host_sda_oe,
    input  scl,
    input  sda
  );

  modport device (
    output dev_sda_out,
    output dev_sda_oe,
    input  scl,
    input  sda
  );
endinterface : i2crap_bus_if
`default_nettype wire

/* File: shared/i2crap_pkg.sv */
// Behaviour
// - Respond only to address bytes 0x68, 0x69
// - Host write: start, 0x68, index, data, stop
// - Device acknowledges each byte of a write
// - Host read: start, 0x68, index, restart, 0x69
// - Device acknowledges index and read address
// - Device shifts out the indexed register contents
// - Host leaves last read byte unacknowledged, stops
// - Auto-increment bit advances pointer during bursts
`default_nettype none
package i2crap_pkg;
  // -------------------------------------------------------------------
  // Bus addressing and register layout
  // -------------------------------------------------------------------
  localparam int          BYTE_W           = 8;
  localparam logic [7:0]  ADDR_WR          = 8'h68;
  localparam logic [7:0]  ADDR_RD          = 8'h69;
  localparam int          REG_COUNT        = 64;
  localparam logic [7:0]  REG_RESET        = 8'h00;
  localparam logic [7:0]  CFG_INDEX        = 8'h01;
  localparam int          CFG_AUTO_INC_BIT = 7;
  localparam logic [7:0]  READ_IDLE_BYTE   = 8'hFF;
  localparam logic [3:0]  ACK_SLOT         = 4'h8;
  localparam logic [3:0]  LAST_BIT         = 4'h7;

  // -------------------------------------------------------------------
  // Timing
  // -------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCL_PERIOD_NS = 2500;
  // Quarter of a serial clock period, rounded down
  localparam int SCL_QTR_CYC   = SCL_PERIOD_NS / (CLK_PERIOD_NS * 4);

  // -------------------------------------------------------------------
  // State encodings
  // -------------------------------------------------------------------
  typedef enum logic [5:0] {
    DS_IDLE = 6'h01,
    DS_RX   = 6'h02,
    DS_ACK  = 6'h04,
    DS_TX   = 6'h08,
    DS_RACK = 6'h10,
    DS_WAIT = 6'h20
  } i2crap_dev_st_t;

  typedef enum logic [3:0] {
    HS_IDLE  = 4'h1,
    HS_START = 4'h2,
    HS_BYTE  = 4'h4,
    HS_STOP  = 4'h8
  } i2crap_host_st_t;
endpackage : i2crap_pkg
`default_nettype wire

/* File: tb/i2crap_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module i2crap_properties (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  import i2crap_pkg::*;
  // ---------------------------------------------------------------
  // Frame tracking rebuilt from the wire
  // ---------------------------------------------------------------
  logic       scl_ff;
  logic       sda_ff;
  logic [3:0] bit_ff;
  logic [1:0] byte_ff;
  logic [7:0] sh_ff;
  logic [7:0] addr_ff;
  logic       rise;
  logic       stop;
  logic       ack;
  assign rise = scl && !scl_ff;
  assign stop = scl && scl_ff && !sda_ff && sda;
  assign ack  = rise && bit_ff == ACK_SLOT;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      scl_ff  <= 1'b1;
      sda_ff  <= 1'b1;
      bit_ff  <= 4'h0;
      byte_ff <= 2'h0;
      sh_ff   <= 8'h00;
      addr_ff <= 8'h00;
    end else begin
      scl_ff <= scl;
      sda_ff <= sda;
      if (scl && scl_ff && sda_ff && !sda) begin
        bit_ff  <= 4'h0;
        byte_ff <= 2'h0;
      end else if (ack) begin
        bit_ff  <= 4'h0;
        byte_ff <= (byte_ff == 2'h3) ? 2'h3 : byte_ff + 2'h1;
        if (byte_ff == 2'h0) begin
          addr_ff <= sh_ff;
        end
      end else if (rise) begin
        bit_ff <= bit_ff + 4'h1;
        sh_ff  <= {sh_ff[6:0], sda};
      end
    end
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_addr_ack: assert property (ack && byte_ff == 2'h0 &&
    (sh_ff == ADDR_WR || sh_ff == ADDR_RD) |-> !sda)
    else $error("address byte not acknowledged");
  a_index_ack: assert property (ack && byte_ff == 2'h1 &&
    addr_ff == ADDR_WR |-> !sda) else $error("index not acknowledged");
  a_data_ack: assert property (ack && byte_ff == 2'h2 &&
    addr_ff == ADDR_WR |-> !sda) else $error("data not acknowledged");
  a_host_nack: assert property (ack && byte_ff == 2'h1 &&
    addr_ff == ADDR_RD |-> sda) else $error("read byte acknowledged");
  a_addr_quiet: assert property (rise && byte_ff == 2'h0 &&
    bit_ff < ACK_SLOT |-> !dev_sda_oe) else $error("device drove address");
  a_rd_owner: assert property (rise && byte_ff == 2'h1 &&
    addr_ff == ADDR_RD && bit_ff < ACK_SLOT |-> !host_sda_oe)
    else $error("host drove read data");
  a_oe_stable: assert property ($changed(dev_sda_oe) |->
    !scl && !$past(scl)) else $error("device changed data with clock high");
  a_stop_idle: assert property (stop |->
    (!dev_sda_oe && !host_sda_oe) [*4]) else $error("data held after stop");
  c_data_ack: cover property (ack && byte_ff == 2'h2 && !sda);
  c_read_end: cover property (ack && byte_ff == 2'h1 && addr_ff == ADDR_RD);
  c_stop: cover property (stop);
endmodule : i2crap_properties
`default_nettype wire

/* File: tb/i2crap_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module i2crap_tb_top;
  import i2crap_pkg::*;
  logic       clock;
  logic       rst_b;
  logic       cmd_valid;
  logic       cmd_read;
  logic       loc_wr_en;
  logic       bscl_oe;
  logic       bsda_oe;
  logic       ack;
  logic       bb_ack;
  logic [7:0] cmd_index;
  logic [7:0] cmd_wdata;
  logic [7:0] loc_wr_index;
  logic [7:0] loc_wr_data;
  logic [7:0] ix;
  logic [7:0] got;
  logic       cmd_ready;
  logic       done;
  logic       nack_err;
  logic       wr_pulse;
  logic       auto_inc;
  logic       busy;
  logic [7:0] rd_data;
  logic [7:0] wr_index;
  logic [7:0] wr_data;
  logic [7:0] mem [64];
  int         mismatches = 0;
  int         check_count = 0;
  int         cycles = 0;
  int         pulses = 0;
  int         exp_pulses = 0;
  i2crap_bus_if bus ();
  i2crap_bus_if bus2 ();
  // Second link is bit-banged by the bench to inject faults
  assign bus2.host_scl_out = 1'b0;
  assign bus2.host_sda_out = 1'b0;
  assign bus2.host_scl_oe  = bscl_oe;
  assign bus2.host_sda_oe  = bsda_oe;
  i2crap_host u_i2crap_host (.clock(clock), .rst_b(rst_b), .bus(bus.host),
    .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_index(cmd_index),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .done(done),
    .rd_data(rd_data), .nack_err(nack_err));
  i2crap_device u_i2crap_device (.clock(clock), .rst_b(rst_b),
    .bus(bus.device), .loc_wr_en(loc_wr_en), .loc_wr_index(loc_wr_index),
    .loc_wr_data(loc_wr_data), .wr_pulse(wr_pulse), .wr_index(wr_index),
    .wr_data(wr_data), .auto_inc(auto_inc), .busy(busy));
  i2crap_device u_i2crap_device_2 (.clock(clock), .rst_b(rst_b),
    .bus(bus2.device), .loc_wr_en(loc_wr_en), .loc_wr_index(loc_wr_index),
    .loc_wr_data(loc_wr_data), .wr_pulse(), .wr_index(), .wr_data(),
    .auto_inc(), .busy());
  i2crap_properties u_i2crap_properties (.clock(clock), .rst_b(rst_b),
    .host_sda_oe(bus.host_sda_oe), .dev_sda_oe(bus.dev_sda_oe),
    .scl(bus.scl), .sda(bus.sda));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (wr_pulse === 1'b1) pulses++;
    if (cycles == 80000) begin
      mismatches++;
      finish_test();
    end
  end
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] exp_rd(input logic [7:0] i);
    return (i < REG_COUNT) ? mem[i[5:0]] : 8'h00;
  endfunction : exp_rd
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  task automatic xfer(input logic rd, input logic [7:0] i, input logic [7:0] d);
    int n;
    while (cmd_ready !== 1'b1) @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_read  <= rd;
    cmd_index <= i;
    cmd_wdata <= d;
    @(posedge clock);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
      if (n == 60) check(busy, 1'b1);
      if (n == 60) check(cmd_ready, 1'b0);
    end while (done !== 1'b1 && n < 2000);
    check(done, 1'b1);
    check(nack_err, 1'b0);
  endtask : xfer
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    xfer(1'b0, i, d);
    // Out-of-range writes still pulse and report; only the store is dropped
    exp_pulses++;
    check(wr_index, i);
    check(wr_data, d);
    if (i < REG_COUNT) mem[i[5:0]] = d;
    @(posedge clock);
  endtask : wr
  task automatic rd(input logic [7:0] i);
    xfer(1'b1, i, 8'h00);
    check(rd_data, exp_rd(i));
    @(posedge clock);
  endtask : rd
  task automatic q();
    repeat (2) @(posedge clock);
  endtask : q
  task automatic bb_start();
    bsda_oe <= 1'b0;
    q();
    bscl_oe <= 1'b0;
    q();
    bsda_oe <= 1'b1;
    q();
    bscl_oe <= 1'b1;
    q();
  endtask : bb_start
  task automatic bb_byte(input logic [7:0] b, output logic [7:0] g,
                         output logic a);
    for (int i = 8; i >= 0; i--) begin
      bsda_oe <= (i > 0) ? !b[i-1] : bb_ack;
      q();
      bscl_oe <= 1'b0;
      q();
      if (i > 0) g[i-1] = bus2.sda;
      else a = bus2.sda;
      q();
      bscl_oe <= 1'b1;
      q();
    end
  endtask : bb_byte
  task automatic bb_stop();
    bsda_oe <= 1'b1;
    q();
    bscl_oe <= 1'b0;
    q();
    bsda_oe <= 1'b0;
    q();
  endtask : bb_stop
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {cmd_valid, cmd_read, cmd_index, cmd_wdata} = '0;
    {loc_wr_en, loc_wr_index, loc_wr_data, bscl_oe, bsda_oe} = '0;
    bb_ack = 1'b0;
    foreach (mem[i]) mem[i] = 8'h00;
    rst_b = 1'b0;
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    void'($urandom(32'h2DB8D51C));
    @(posedge clock);
    check(auto_inc, 1'b0);
    check(busy, 1'b0);
    check(cmd_ready, 1'b1);
    rd(8'h05);
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      ix = (i == 0) ? 8'h3F : 8'($urandom_range(63));
      wr(ix, 8'($urandom));
      rd(8'($urandom_range(63)));
      rd(ix);
    end
    $display("test random done");
    // Out-of-range writes are acked but dropped
    wr(8'h40, 8'h5A);
    wr(8'hFF, 8'hA5);
    rd(8'h40);
    rd(8'hFF);
    for (int i = 0; i < 4; i++) begin
      // Index kept off the config register so burst mode stays off
      ix = (i == 3) ? 8'h41 : 8'(8'h10 + $urandom_range(47));
      loc_wr_en <= 1'b1;
      loc_wr_index <= ix;
      loc_wr_data <= 8'($urandom);
      @(posedge clock);
      loc_wr_en <= 1'b0;
      if (ix < REG_COUNT) mem[ix[5:0]] = loc_wr_data;
      rd(ix);
    end
    $display("test local done");
    wr(CFG_INDEX, 8'h80);
    check(auto_inc, 1'b1);
    rd(CFG_INDEX);
    wr(CFG_INDEX, 8'h00);
    check(auto_inc, 1'b0);
    check(8'(pulses), 8'(exp_pulses));
    $display("test config done");
    bb_start();
    bb_byte(8'h50, got, ack);
    check(ack, 1'b1);
    bb_stop();
    bb_start();
    for (int i = 0; i < 4; i++) begin
      bb_byte((i == 0) ? ADDR_WR : 8'h07 + 8'((i - 1) * 8'h51), got, ack);
      check(ack, (i == 3));
    end
    bb_stop();
    bb_start();
    bb_byte(ADDR_WR, got, ack);
    bb_byte(8'h07, got, ack);
    bb_start();
    bb_byte(ADDR_RD, got, ack);
    check(ack, 1'b0);
    bb_byte(8'hFF, got, ack);
    check(got, 8'h58);
    bb_stop();
    // Burst read with auto-increment on: an acked byte moves the pointer
    bb_start();
    bb_byte(ADDR_WR, got, ack);
    bb_byte(CFG_INDEX, got, ack);
    bb_byte(8'h80, got, ack);
    bb_stop();
    bb_start();
    bb_byte(ADDR_WR, got, ack);
    bb_byte(8'h07, got, ack);
    bb_start();
    bb_byte(ADDR_RD, got, ack);
    bb_ack = 1'b1;
    bb_byte(8'hFF, got, ack);
    check(got, 8'h58);
    bb_ack = 1'b0;
    bb_byte(8'hFF, got, ack);
    check(got, 8'h00);
    bb_stop();
    $display("test link faults done");
    finish_test();
  end
endmodule : i2crap_tb_top
`default_nettype wire
